//--- rtl/drive_ref_pkg.sv
// Purpose: shared constants and types for the drive reference and status logic
// Assumes: frequencies in 0.01 Hz units, torque in 0.1 % units, times in 0.1 s or 10 ms units
// Notes:   one cycle is 10 ns
package drive_ref_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FREQ_W = 14;
    localparam int TORQ_W = 12;
    localparam int TIME_W = 16;
    localparam int NUM_PRESETS = 15;
    localparam int NUM_STAGES = 7;
    localparam int NUM_SKIPS = 3;
    localparam logic [FREQ_W-1:0] FREQ_MAX = 14'h2EE0;
    localparam logic [FREQ_W-1:0] SKIP_WIDTH_MAX = 14'h0BB8;
    localparam logic [TORQ_W-1:0] TORQ_LEVEL_MAX = 12'hBB8;
    localparam logic [TORQ_W-1:0] TORQ_HYST = 12'h032;
    localparam logic [TIME_W-1:0] TORQ_TIMER_MAX = 16'hEA60;
    localparam logic [TIME_W-1:0] STAGE_TIME_MAX = 16'h8CA0;
    localparam logic [3:0] SRC_PATTERN = 4'hA;
    localparam int LOW_TORQ_MIN_ON_MS = 100;
    localparam int MIN_ON_CYCLES = (LOW_TORQ_MIN_ON_MS * 1000000) / CLK_PERIOD_NS;
    localparam int TICK10MS_NS = 10000000;
    localparam int TICK10MS_CYCLES = TICK10MS_NS / CLK_PERIOD_NS;
    localparam int TICK100MS_PER_10MS = 10;
    localparam int SLOW_FREQ_PCT = 20;
    localparam int PCT_FULL = 100;

    typedef enum logic [1:0] {
        PAT_ONCE_STOP = 2'b00,
        PAT_REPEAT    = 2'b01,
        PAT_ONCE_RUN  = 2'b10
    } pattern_mode_t;

    typedef struct packed {
        logic [TIME_W-1:0] runTime;
        logic              reverse;
        logic [1:0]        accelSel;
    } stage_t;
endpackage

//--- rtl/drive_reference_and_status.sv
// Purpose: reference frequency selection, pattern sequencer and status flags
// Assumes: settings are held stable by the keypad logic; torque and dc inputs are sampled values
// Notes:   one clock, asynchronous active-low reset
// Overview of operation
// RL1: low dc-link flag on while voltage below level, off once above.
// RL2: low-torque flag on after torque stays below level for timer duration.
// RL3: low-torque flag releases only above level plus five percent hysteresis.
// RL4: low-torque flag stays on at least 100 ms once set.
// RL5: below 20% base frequency, torque evaluation freezes, flag state kept.
// RL6: low-torque flag forced off while drive is stopped.
// RL7: skip band holds at bottom rising, at top falling, until crossed.
// RL8: overlapping skip bands merge from lowest bottom to highest top.
// RL9: three skip centres up to 120 Hz; zero centre means no band.
// RL10: one common skip width up to 30 Hz; zero disables skipping.
// RL11: four select inputs form binary index choosing preset n.
// RL12: index zero takes reference from frequency setting 1 or 2.
// RL13: presets accept 0.00 to 120.0 Hz.
// RL14: operator selects frequency source ten to run pattern operation.
// RL15: pattern mode 0 runs sequence once then stops motor.
// RL16: pattern mode 1 repeats and stops at once on stop command.
// RL17: pattern mode 2 runs once then keeps normal reference.
// RL18: seven stages each have run time up to 3600 s and direction.
// RL19: each stage selects one of four accel/decel time pairs.
// RL20: stage with zero run time is skipped.
// RL21: stage k uses preset frequency k as reference.
// RL22: stage settings commit together only after all three entered.
// RL23: stages advance in ascending order on run-time expiry.
// RL24: stop after completed cycle decelerates with deceleration time 1.
// RL25: pattern direction follows stage setting regardless of run command.
`timescale 1ns/1ps
`default_nettype none
module drive_reference_and_status (
    // clock and reset
    input  wire logic                                clock,
    input  wire logic                                nrst,
    // step select terminals
    input  wire logic                                stepSelectW1,
    input  wire logic                                stepSelectW2,
    input  wire logic                                stepSelectW4,
    input  wire logic                                stepSelectW8,
    // frequency settings
    input  wire logic [3:0]                          freqSourceSelect,
    input  wire logic                                useFreqSourceAlt,
    input  wire logic [drive_ref_pkg::FREQ_W-1:0]    freqSetting1,
    input  wire logic [drive_ref_pkg::FREQ_W-1:0]    freqSetting2,
    input  wire logic [drive_ref_pkg::FREQ_W-1:0]    presetFreq [drive_ref_pkg::NUM_PRESETS],
    // skip bands
    input  wire logic [drive_ref_pkg::FREQ_W-1:0]    skipCenter [drive_ref_pkg::NUM_SKIPS],
    input  wire logic [drive_ref_pkg::FREQ_W-1:0]    skipBandWidth,
    // pattern sequencer settings and entry
    input  wire logic [1:0]                          patternModeSelect,
    input  wire logic [2:0]                          stageEntryIndex,
    input  wire logic                                stageEntryStep,
    input  wire logic                                stageEntryAbort,
    input  wire drive_ref_pkg::stage_t               stageEntryData,
    // run commands
    input  wire logic                                runCmd,
    input  wire logic                                stopCmd,
    // status inputs
    input  wire logic [drive_ref_pkg::FREQ_W-1:0]    outputFreq,
    input  wire logic [drive_ref_pkg::FREQ_W-1:0]    baseFrequencySetting,
    input  wire logic [drive_ref_pkg::TORQ_W-1:0]    calcTorque,
    input  wire logic [drive_ref_pkg::TORQ_W-1:0]    lowTorqueLevel,
    input  wire logic [drive_ref_pkg::TIME_W-1:0]    lowTorqueTimer,
    input  wire logic                                useTorqueHyst,
    input  wire logic [11:0]                         dcLinkVolt,
    input  wire logic [11:0]                         dcLinkLowLevel,
    // outputs to motor control core
    output logic      [drive_ref_pkg::FREQ_W-1:0]    refFreq,
    output logic                                     driveRun,
    output logic                                     driveReverse,
    output logic      [1:0]                          accelDecelSel,
    output logic      [2:0]                          activeStage,
    output logic                                     patternActive,
    // status flags
    output logic                                     dcLinkLowFlag,
    output logic                                     lowTorqueFlag
);
    import drive_ref_pkg::*;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_RUN  = 2'b01,
        SEQ_DONE = 2'b10
    } seq_state_t;

    // committed stage table and entry staging
    stage_t            stage_r [NUM_STAGES];
    stage_t            stageHold_r;
    logic [1:0]        entryCount_r;
    // time base
    logic [23:0]       tick10Cnt_r;
    logic              tick10ms;
    logic [3:0]        tick100Cnt_r;
    logic              tick100ms;
    // sequencer
    seq_state_t        seqState_r;
    logic [2:0]        stage_r_idx;
    logic [TIME_W-1:0] stageTime_r;
    logic              patternSel;
    // reference path
    logic [3:0]        stepIndex;
    logic [FREQ_W-1:0] reqFreq;
    logic [FREQ_W-1:0] skippedFreq;
    // torque detector
    logic [TIME_W-1:0] lowTimeCnt_r;
    logic [24:0]       minOnCnt_r;
    logic              slowRange;
    logic [TORQ_W:0]   releaseLevel;

    function automatic logic [2:0] nextLiveStage(input logic [2:0] from, input stage_t tbl [NUM_STAGES]);
        logic [2:0] n;
        n = 3'h7;
        for (int i = NUM_STAGES - 1; i >= 0; i--) begin
            if (i >= int'(from) && tbl[i].runTime != '0) n = 3'(i); // [RL20]
        end
        return n;
    endfunction

    function automatic logic [FREQ_W-1:0] clampFreq(input logic [FREQ_W-1:0] f, input logic [FREQ_W-1:0] lim);
        return (f > lim) ? lim : f;
    endfunction

    assign stepIndex  = {stepSelectW8, stepSelectW4, stepSelectW2, stepSelectW1}; // [RL11]
    assign patternSel = (freqSourceSelect == SRC_PATTERN); // [RL14]

    // stage entry: three presses stage one set, commit only on the third
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            entryCount_r <= 2'h0;
            stageHold_r  <= '0;
            for (int i = 0; i < NUM_STAGES; i++) stage_r[i] <= '0;
        end else if (stageEntryAbort) begin
            entryCount_r <= 2'h0; // [RL22]
        end else if (stageEntryStep && stageEntryIndex < 3'h7) begin
            unique case (entryCount_r)
                2'h0: begin
                    stageHold_r.runTime <= (stageEntryData.runTime > STAGE_TIME_MAX) ?
                                           STAGE_TIME_MAX : stageEntryData.runTime; // [RL18]
                    entryCount_r <= 2'h1;
                end
                2'h1: begin
                    stageHold_r.reverse <= stageEntryData.reverse; // [RL18]
                    entryCount_r <= 2'h2;
                end
                2'h2: begin
                    stage_r[stageEntryIndex] <= '{stageHold_r.runTime, stageHold_r.reverse,
                                                  stageEntryData.accelSel}; // [RL22] [RL19]
                    entryCount_r <= 2'h0;
                end
                default: entryCount_r <= 2'h0;
            endcase
        end
    end

    // 10 ms and 100 ms ticks for stage and torque timers
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tick10Cnt_r  <= '0;
            tick100Cnt_r <= '0;
        end else begin
            if (tick10ms) begin
                tick10Cnt_r  <= '0;
                tick100Cnt_r <= (tick100Cnt_r == 4'(TICK100MS_PER_10MS - 1)) ? 4'h0 : tick100Cnt_r + 4'h1;
            end else begin
                tick10Cnt_r <= tick10Cnt_r + 24'h000001;
            end
        end
    end
    assign tick10ms  = (tick10Cnt_r == 24'(TICK10MS_CYCLES - 1));
    assign tick100ms = tick10ms && (tick100Cnt_r == 4'(TICK100MS_PER_10MS - 1));

    // pattern sequencer
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            seqState_r  <= SEQ_IDLE;
            stage_r_idx <= 3'h0;
            stageTime_r <= '0;
        end else begin
            unique case (seqState_r)
                SEQ_IDLE: begin
                    if (patternSel && runCmd && !stopCmd && nextLiveStage(3'h0, stage_r) != 3'h7) begin
                        stage_r_idx <= nextLiveStage(3'h0, stage_r);
                        stageTime_r <= '0;
                        seqState_r  <= SEQ_RUN;
                    end
                end
                SEQ_RUN: begin
                    if (stopCmd || !runCmd || !patternSel) begin
                        seqState_r <= SEQ_IDLE; // [RL16]
                    end else if (tick100ms) begin
                        if (stageTime_r + 16'h0001 >= stage_r[stage_r_idx].runTime) begin
                            stageTime_r <= '0;
                            if (stage_r_idx != 3'(NUM_STAGES - 1) &&
                                nextLiveStage(stage_r_idx + 3'h1, stage_r) != 3'h7) begin
                                stage_r_idx <= nextLiveStage(stage_r_idx + 3'h1, stage_r); // [RL23] [RL20]
                            end else if (patternModeSelect == PAT_REPEAT) begin
                                stage_r_idx <= nextLiveStage(3'h0, stage_r); // [RL16] [RL23]
                            end else begin
                                seqState_r <= SEQ_DONE; // [RL15] [RL17]
                            end
                        end else begin
                            stageTime_r <= stageTime_r + 16'h0001;
                        end
                    end
                end
                SEQ_DONE: begin
                    // hold until run drops so a held run terminal does not restart the cycle
                    if (!runCmd || !patternSel) seqState_r <= SEQ_IDLE;
                end
                default: seqState_r <= SEQ_IDLE;
            endcase
        end
    end

    // requested frequency before skip bands
    always_comb begin
        if (seqState_r == SEQ_RUN)
            reqFreq = clampFreq(presetFreq[stage_r_idx], FREQ_MAX); // [RL21] [RL13]
        else if (stepIndex != 4'h0)
            reqFreq = clampFreq(presetFreq[stepIndex - 4'h1], FREQ_MAX); // [RL11] [RL13]
        else if (useFreqSourceAlt)
            reqFreq = freqSetting2; // [RL12]
        else
            reqFreq = freqSetting1; // [RL12]
    end

    skip_band uSkip (
        .clock     (clock),
        .nrst      (nrst),
        .skipCenter(skipCenter),
        .skipWidth (clampFreq(skipBandWidth, SKIP_WIDTH_MAX)), // [RL10]
        .freqReq   (reqFreq),
        .freqOut   (skippedFreq)
    );

    // outputs toward the motor core
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            refFreq       <= '0;
            driveRun      <= 1'b0;
            driveReverse  <= 1'b0;
            accelDecelSel <= 2'h0;
            activeStage   <= 3'h0;
            patternActive <= 1'b0;
        end else begin
            refFreq       <= skippedFreq;
            patternActive <= (seqState_r == SEQ_RUN);
            activeStage   <= (seqState_r == SEQ_RUN) ? stage_r_idx + 3'h1 : 3'h0;
            if (seqState_r == SEQ_RUN) begin
                driveRun      <= 1'b1;
                driveReverse  <= stage_r[stage_r_idx].reverse; // [RL25]
                accelDecelSel <= stage_r[stage_r_idx].accelSel; // [RL19]
            end else if (seqState_r == SEQ_DONE && patternModeSelect != PAT_ONCE_RUN) begin
                driveRun      <= 1'b0; // [RL15]
                accelDecelSel <= 2'h0; // [RL24]
            end else begin
                driveRun      <= runCmd && !stopCmd && !patternSel ? 1'b1 :
                                 (seqState_r == SEQ_DONE && runCmd && !stopCmd); // [RL17]
                accelDecelSel <= 2'h0;
            end
        end
    end

    // dc-link low flag, plain comparison so it tracks both directions
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) dcLinkLowFlag <= 1'b0;
        else if (dcLinkVolt < dcLinkLowLevel) dcLinkLowFlag <= 1'b1; // [RL1]
        else if (dcLinkVolt > dcLinkLowLevel) dcLinkLowFlag <= 1'b0; // [RL1]
    end

    // low-torque detector
    assign slowRange = (32'(outputFreq) * PCT_FULL) < (32'(baseFrequencySetting) * SLOW_FREQ_PCT); // [RL5]
    assign releaseLevel = useTorqueHyst ? ({1'b0, lowTorqueLevel} + {1'b0, TORQ_HYST})
                                        : {1'b0, lowTorqueLevel}; // [RL3]

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lowTimeCnt_r  <= '0;
            minOnCnt_r    <= '0;
            lowTorqueFlag <= 1'b0;
        end else if (!driveRun) begin
            lowTimeCnt_r  <= '0;
            minOnCnt_r    <= '0;
            lowTorqueFlag <= 1'b0; // [RL6]
        end else if (slowRange) begin
            // torque estimate unreliable here; low-time counter and flag frozen, minimum on-time keeps counting down
            if (minOnCnt_r != '0) minOnCnt_r <= minOnCnt_r - 25'h1; // [RL5]
        end else begin
            if (minOnCnt_r != '0) minOnCnt_r <= minOnCnt_r - 25'h1;
            if (!lowTorqueFlag) begin
                if (calcTorque < lowTorqueLevel) begin
                    if (tick10ms) lowTimeCnt_r <= lowTimeCnt_r + 16'h0001;
                    if (lowTimeCnt_r >= lowTorqueTimer) begin
                        lowTorqueFlag <= 1'b1; // [RL2]
                        minOnCnt_r    <= 25'(MIN_ON_CYCLES - 1); // [RL4]
                    end
                end else begin
                    lowTimeCnt_r <= '0;
                end
            end else if ({1'b0, calcTorque} > releaseLevel && minOnCnt_r == '0) begin // [RL3] [RL4]
                lowTorqueFlag <= 1'b0;
                lowTimeCnt_r  <= '0;
            end
        end
    end
endmodule // drive_reference_and_status
`default_nettype wire

//--- rtl/skip_band.sv
// Purpose: bends a requested frequency around three skip bands
// Assumes: request changes slowly relative to the clock
// Notes:   overlapping bands merge before the hold logic sees them
`timescale 1ns/1ps
`default_nettype none
module skip_band (
    // clock and reset
    input  wire logic                              clock,
    input  wire logic                              nrst,
    // settings
    input  wire logic [drive_ref_pkg::FREQ_W-1:0]  skipCenter [drive_ref_pkg::NUM_SKIPS],
    input  wire logic [drive_ref_pkg::FREQ_W-1:0]  skipWidth,
    // request and result
    input  wire logic [drive_ref_pkg::FREQ_W-1:0]  freqReq,
    output logic      [drive_ref_pkg::FREQ_W-1:0]  freqOut
);
    localparam int W = drive_ref_pkg::FREQ_W;
    logic [W:0]   lo [drive_ref_pkg::NUM_SKIPS];
    logic [W:0]   hi [drive_ref_pkg::NUM_SKIPS];
    logic         act [drive_ref_pkg::NUM_SKIPS];
    logic [W:0]   mLo;
    logic [W:0]   mHi;
    logic         inBand;
    logic [W-1:0] prevReq_r;
    logic [W-1:0] freqOut_nxt;

    genvar g;
    generate
        for (g = 0; g < drive_ref_pkg::NUM_SKIPS; g++) begin : gBand
            logic [W:0] half;
            assign half = {2'b00, skipWidth[W-1:1]};
            assign act[g] = (skipCenter[g] != '0) && (skipWidth != '0); // [RL9] [RL10]
            assign lo[g] = ({1'b0, skipCenter[g]} > half) ? ({1'b0, skipCenter[g]} - half) : '0;
            assign hi[g] = {1'b0, skipCenter[g]} + half;
        end
    endgenerate

    // merge every band that overlaps the one holding the request
    always_comb begin
        mLo = '0;
        mHi = '0;
        inBand = 1'b0;
        for (int i = 0; i < drive_ref_pkg::NUM_SKIPS; i++) begin
            if (act[i] && ({1'b0, freqReq} > lo[i]) && ({1'b0, freqReq} < hi[i])) begin
                inBand = 1'b1;
                mLo = lo[i];
                mHi = hi[i];
            end
        end
        // two passes reach a chain of three bands
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < drive_ref_pkg::NUM_SKIPS; i++) begin
                if (inBand && act[i] && (lo[i] <= mHi) && (hi[i] >= mLo)) begin // [RL8]
                    if (lo[i] < mLo) mLo = lo[i];
                    if (hi[i] > mHi) mHi = hi[i];
                end
            end
        end
    end

    always_comb begin
        freqOut_nxt = freqReq;
        if (inBand) begin
            // rising holds at bottom, falling at top; unchanged keeps the last side
            if (freqReq > prevReq_r)
                freqOut_nxt = mLo[W-1:0]; // [RL7]
            else if (freqReq < prevReq_r)
                freqOut_nxt = mHi[W-1:0]; // [RL7]
            else
                freqOut_nxt = freqOut;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prevReq_r <= '0;
            freqOut   <= '0;
        end else begin
            prevReq_r <= freqReq;
            freqOut   <= freqOut_nxt;
        end
    end
endmodule // skip_band
`default_nettype wire

//--- test/drive_ref_checker_sva.sv
// Purpose: port assertions for the drive reference logic
// Assumes: bound to the top design module
// Notes:   100 ms low-torque timing is beyond a short run
`timescale 1ns/1ps
`default_nettype none
module drive_ref_checker (
    // clock and reset
    input wire logic        clock,
    input wire logic        nrst,
    // watched inputs
    input wire logic [3:0]  freqSourceSelect,
    input wire logic        runCmd,
    input wire logic        stopCmd,
    input wire logic [11:0] dcLinkVolt,
    input wire logic [11:0] dcLinkLowLevel,
    // watched outputs
    input wire logic        driveRun,
    input wire logic [2:0]  activeStage,
    input wire logic        patternActive,
    input wire logic        dcLinkLowFlag,
    input wire logic        lowTorqueFlag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    AST_DC_SET: assert property (dcLinkVolt < dcLinkLowLevel |=> dcLinkLowFlag)
        else $error("dc flag not set below level");
    AST_DC_CLR: assert property (dcLinkVolt > dcLinkLowLevel |=> !dcLinkLowFlag)
        else $error("dc flag not cleared above level");
    AST_DC_HOLD: assert property (dcLinkVolt == dcLinkLowLevel |=> $stable(dcLinkLowFlag))
        else $error("dc flag moved at equal level");
    AST_TQ_STOP: assert property (!driveRun ##1 !driveRun |-> !lowTorqueFlag)
        else $error("low torque flag on while stopped");
    AST_TQ_MINON: assert property ($rose(lowTorqueFlag) ##1 driveRun [*8] |-> lowTorqueFlag)
        else $error("low torque flag dropped early");
    AST_SEQ_STOP: assert property (stopCmd |-> ##2 !patternActive)
        else $error("pattern still active after stop");
    AST_SEQ_SRC: assert property ($rose(patternActive) |->
        $past(freqSourceSelect) == drive_ref_pkg::SRC_PATTERN && $past(runCmd))
        else $error("pattern started without source or run");
    AST_SEQ_FIRST: assert property ($rose(patternActive) |-> activeStage != 3'h0 && driveRun)
        else $error("pattern start without stage or run");
    cover property ($rose(dcLinkLowFlag));
    cover property ($rose(patternActive));
    cover property (stopCmd && patternActive);
endmodule // drive_ref_checker
`default_nettype wire

//--- test/motor_core_model.sv
// Purpose: motor control core stand-in
// Assumes: speed snaps to the reference, no ramp
// Notes:   torque held under any sensible low level
`timescale 1ns/1ps
`default_nettype none
module motor_core_model (
    // clock and reset
    input wire logic                             clock,
    input wire logic                             nrst,
    // reference in
    input wire logic [drive_ref_pkg::FREQ_W-1:0] refFreq,
    input wire logic                             driveRun,
    // feedback out
    output logic     [drive_ref_pkg::FREQ_W-1:0] outputFreq,
    output logic     [drive_ref_pkg::TORQ_W-1:0] calcTorque
);
    // stopped motor reads zero speed, which gates torque checks
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            outputFreq <= 14'h0000;
        end else begin
            outputFreq <= driveRun ? refFreq : 14'h0000;
        end
    end
    assign calcTorque = 12'h010;
endmodule // motor_core_model
`default_nettype wire

//--- test/tb.sv
// Purpose: self-checking bench for the drive reference logic
// Assumes: inputs driven and outputs read at falling edge
// Notes:   stage timers and the 100 ms minimum on-time are too long to run out; torque timer is zero
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef logic [drive_ref_pkg::FREQ_W-1:0] freq_t;
    logic clock;
    logic nrst = 1'b0, runCmd = 1'b0, stopCmd = 1'b0, useAlt = 1'b0;
    logic eStep = 1'b0, eAbort = 1'b0;
    logic [3:0] stepSel = 4'h0, srcSel = 4'h0;
    logic [1:0] patMode = 2'h0, adSel;
    logic [2:0] eIdx = 3'h0, stage;
    freq_t set1 = 14'h0064, set2 = 14'h00C8, width = 14'h0000, refFreq, outFreq;
    freq_t preset [15];
    freq_t center [3];
    logic [11:0] volt = 12'h200, vLevel = 12'h100, tLevel = 12'h100, torque;
    drive_ref_pkg::stage_t eData = '0;
    logic driveRun, driveRev, patAct, dcFlag, tqFlag;
    int numErrors = 0, testsRun = 0;
    drive_reference_and_status dut (
        .clock(clock), .nrst(nrst), .stepSelectW1(stepSel[0]), .stepSelectW2(stepSel[1]),
        .stepSelectW4(stepSel[2]), .stepSelectW8(stepSel[3]),
        .freqSourceSelect(srcSel), .useFreqSourceAlt(useAlt),
        .freqSetting1(set1), .freqSetting2(set2), .presetFreq(preset),
        .skipCenter(center), .skipBandWidth(width), .runCmd(runCmd), .stopCmd(stopCmd),
        .patternModeSelect(patMode), .stageEntryIndex(eIdx),
        .stageEntryStep(eStep), .stageEntryAbort(eAbort), .stageEntryData(eData),
        .outputFreq(outFreq), .baseFrequencySetting(14'h1770),
        .calcTorque(torque), .lowTorqueLevel(tLevel), .lowTorqueTimer(16'h0000), .useTorqueHyst(1'b0),
        .dcLinkVolt(volt), .dcLinkLowLevel(vLevel), .dcLinkLowFlag(dcFlag), .lowTorqueFlag(tqFlag),
        .refFreq(refFreq), .driveRun(driveRun), .driveReverse(driveRev),
        .accelDecelSel(adSel), .activeStage(stage), .patternActive(patAct)
    );
    motor_core_model core (.clock(clock), .nrst(nrst), .refFreq(refFreq),
        .driveRun(driveRun), .outputFreq(outFreq), .calcTorque(torque));
    task automatic summarize();
        $display("checks %0d mismatches %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        testsRun++;
        if (got !== exp) begin
            numErrors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask
    // skip result needs two edges; four leaves margin
    task automatic setReq(input freq_t v, input freq_t e);
        set1 = v;
        tick(4);
        chk("refFreq", e, refFreq);
    endtask
    task automatic enter(input logic [2:0] i, input drive_ref_pkg::stage_t d, input int n, input logic ab);
        eIdx = i;
        eData = d;
        repeat (n) begin
            eStep = 1'b1;
            tick(1);
            eStep = 1'b0;
            tick(1);
        end
        eAbort = ab;
        tick(1);
        eAbort = 1'b0;
        tick(1);
    endtask
    task automatic runPat(input logic [1:0] m);
        int k;
        k = 0;
        patMode = m;
        runCmd = 1'b1;
        while (patAct !== 1'b1) begin
            tick(1);
            k++;
            if (k > 50) begin
                numErrors++;
                summarize();
            end
        end
        tick(3);
        chk("activeStage", 16'h0002, stage);
        chk("driveReverse", 16'h0001, driveRev);
        chk("accelDecelSel", 16'h0002, adSel);
        chk("refFreq", 16'h0200, refFreq);
        stopCmd = 1'b1;
        tick(2);
        chk("patternActive", 16'h0000, patAct);
        chk("driveRun", 16'h0000, driveRun);
        runCmd = 1'b0;
        stopCmd = 1'b0;
        tick(2);
    endtask
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        foreach (preset[i]) preset[i] = 14'(16'h0100 * (i + 1));
        foreach (center[i]) center[i] = 14'h0000;
        tick(6);
        nrst = 1'b1;
        tick(2);
        volt = 12'h080;
        tick(2);
        chk("dcLinkLowFlag", 16'h0001, dcFlag);
        volt = 12'h100;
        tick(2);
        chk("dcLinkLowFlag", 16'h0001, dcFlag);
        volt = 12'h180;
        tick(2);
        chk("dcLinkLowFlag", 16'h0000, dcFlag);
        for (int n = 1; n < 16; n++) begin
            stepSel = 4'(n);
            tick(4);
            chk("preset", 16'(16'h0100 * n), refFreq);
        end
        preset[14] = 14'h3FFF;
        tick(4);
        chk("preset", drive_ref_pkg::FREQ_MAX, refFreq);
        stepSel = 4'h0;
        tick(4);
        chk("refFreq", 16'h0064, refFreq);
        useAlt = 1'b1;
        tick(4);
        chk("refFreq", 16'h00C8, refFreq);
        useAlt = 1'b0;
        width = 14'h03E8;
        center[0] = 14'h0BB8;
        setReq(14'h07D0, 14'h07D0);
        setReq(14'h0BB8, 14'h09C4);
        setReq(14'h0E10, 14'h0E10);
        setReq(14'h0BB8, 14'h0DAC);
        setReq(14'h07D0, 14'h07D0);
        center[1] = 14'h0ED8;
        setReq(14'h0FA0, 14'h09C4);
        setReq(14'h1194, 14'h1194);
        setReq(14'h0BB8, 14'h10CC);
        center[0] = 14'h0000;
        center[1] = 14'h0000;
        setReq(14'h0190, 14'h0190);
        center[0] = 14'h0BB8;
        width = 14'h0000;
        setReq(14'h0BB8, 14'h0BB8);
        center[0] = 14'h0000;
        srcSel = drive_ref_pkg::SRC_PATTERN;
        enter(3'h0, '{16'h0005, 1'b1, 2'h1}, 2, 1'b1);
        runCmd = 1'b1;
        tick(20);
        chk("patternActive", 16'h0000, patAct);
        runCmd = 1'b0;
        tick(2);
        enter(3'h1, '{16'h0003, 1'b1, 2'h2}, 3, 1'b0);
        for (int m = 0; m < 3; m++) runPat(2'(m));
        srcSel = 4'h0;
        runCmd = 1'b1;
        tick(12);
        chk("lowTorqueFlag", 16'h0001, tqFlag);
        runCmd = 1'b0;
        tick(3);
        chk("lowTorqueFlag", 16'h0000, tqFlag);
        summarize();
    end
endmodule // tb
bind drive_reference_and_status drive_ref_checker chk_i (
    .clock(clock), .nrst(nrst), .freqSourceSelect(freqSourceSelect),
    .runCmd(runCmd), .stopCmd(stopCmd), .dcLinkVolt(dcLinkVolt),
    .dcLinkLowLevel(dcLinkLowLevel), .driveRun(driveRun), .activeStage(activeStage),
    .patternActive(patternActive), .dcLinkLowFlag(dcLinkLowFlag), .lowTorqueFlag(lowTorqueFlag)
);
`default_nettype wire
